// >>> verilog/dbsp_pkg.sv
// Purpose: shared constants and types for the DDR burst-of-four SRAM port
// Assumes: link edges counted in half cycles of the input clock pair
// Notes:   every figure used by more than one file lives here
package dbsp_pkg;
	// **************************************************
	// geometry
	// **************************************************
	localparam int DATA_W    = 18;
	localparam int ADDR_W    = 20;
	localparam int ARRAY_AW  = 8;
	localparam int LANE_W    = 9;
	localparam int BURST_LEN = 4;

	// **************************************************
	// burst beats
	// **************************************************
	localparam logic [1:0] BEAT_FIRST = 2'h0;
	localparam logic [1:0] BEAT_STEP  = 2'h1;
	localparam logic [1:0] BEAT_LAST  = 2'h3;

	// **************************************************
	// latencies in link half cycles, command edge to launch edge
	// **************************************************
	localparam int RD_LAT_DDR2_HALF = 3;
	localparam int RD_LAT_DDR1_HALF = 2;
	localparam int WR_LAT_HALF      = 2;
	localparam logic [1:0] RD_DELAY_DDR2 = 2'(RD_LAT_DDR2_HALF - 1);
	localparam logic [1:0] RD_DELAY_DDR1 = 2'(RD_LAT_DDR1_HALF - 1);
	localparam logic [1:0] WR_DELAY      = 2'(WR_LAT_HALF - 1);

	// **************************************************
	// strap capture sequence
	// **************************************************
	typedef enum logic [1:0] {
		DBSP_ST_RESET  = 2'h0,
		DBSP_ST_SETTLE = 2'h1,
		DBSP_ST_RUN    = 2'h3
	} dbsp_strap_st_t;
endpackage

// >>> verilog/dbsp_sync.sv
// Purpose: two-stage level synchroniser
// Assumes: input levels are quasi-static relative to the sampling clock
// Notes:   first stage is read only by the second
`timescale 1ns/100ps
module dbsp_sync #(
	parameter int W = 1
) (
	// clock
	input  wire logic         clk,
	// levels
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk)
	begin
		meta_reg <= d;
		q        <= meta_reg;
	end
endmodule // dbsp_sync

// >>> verilog/dbsp_burst_slot.sv
// Purpose: tracks one pending and one active four-beat burst
// Assumes: starts spaced at least four link edges apart
// Notes:   beat outputs are combinational from state, valid on the beat edge
`timescale 1ns/100ps
module dbsp_burst_slot #(
	parameter int AW = dbsp_pkg::ADDR_W
) (
	// clock and run
	input  wire logic          clk,
	input  wire logic          run,
	// request
	input  wire logic          start,
	input  wire logic [AW-1:0] start_addr,
	input  wire logic [1:0]    start_delay,
	// beat
	output logic               beat_v,
	output logic [1:0]         beat_idx,
	output logic [AW-1:0]      beat_addr,
	output logic [AW-1:0]      base_addr,
	output logic               beat_last
);
	logic          pend_v_reg;
	logic [1:0]    pend_cnt_reg;
	logic [AW-1:0] pend_addr_reg;
	logic          act_v_reg;
	logic [1:0]    act_beat_reg;
	logic [AW-1:0] act_addr_reg;
	logic          fire;

	assign fire = pend_v_reg && (pend_cnt_reg == dbsp_pkg::BEAT_FIRST);

	always_comb
	begin
		beat_v    = fire || act_v_reg;
		beat_idx  = fire ? dbsp_pkg::BEAT_FIRST : act_beat_reg;
		base_addr = fire ? pend_addr_reg : act_addr_reg;
		// low two bits count linearly and wrap in the group
		beat_addr = {base_addr[AW-1:2], 2'(base_addr[1:0] + beat_idx)};
		beat_last = beat_v && (beat_idx == dbsp_pkg::BEAT_LAST);
	end

	// **************************************************
	// pending request
	// **************************************************
	always_ff @(posedge clk)
	begin
		if (!run)
		begin
			pend_v_reg    <= 1'b0;
			pend_cnt_reg  <= dbsp_pkg::BEAT_FIRST;
			pend_addr_reg <= '0;
		end
		else if (start)
		begin
			pend_v_reg    <= 1'b1;
			pend_cnt_reg  <= start_delay;
			pend_addr_reg <= start_addr;
		end
		else if (fire)
			pend_v_reg <= 1'b0;
		else if (pend_v_reg)
			pend_cnt_reg <= pend_cnt_reg - dbsp_pkg::BEAT_STEP;
	end

	// **************************************************
	// active burst, four beats
	// **************************************************
	always_ff @(posedge clk)
	begin
		if (!run)
		begin
			act_v_reg    <= 1'b0;
			act_beat_reg <= dbsp_pkg::BEAT_FIRST;
			act_addr_reg <= '0;
		end
		else if (fire)
		begin
			act_v_reg    <= 1'b1;
			act_beat_reg <= dbsp_pkg::BEAT_STEP;
			act_addr_reg <= pend_addr_reg;
		end
		else if (act_v_reg)
		begin
			if (act_beat_reg == dbsp_pkg::BEAT_LAST)
				act_v_reg <= 1'b0;
			act_beat_reg <= act_beat_reg + dbsp_pkg::BEAT_STEP;
		end
	end
endmodule // dbsp_burst_slot

// >>> verilog/dbsp_sram_port.sv
// Purpose: device side of a DDR SRAM port with four-word bursts
// Assumes: link_clk runs at twice the input clock rate, one edge per K or K# rise
// Notes:   array is flip-flops indexed by the low ARRAY_AW address bits
//
// Overview of operation
// - addresses taken only on alternate K rises
// - write words captured on K and K# rises
// - read words launched on K and K# rises, in either clock mode
// - burst counter loads two low address bits
// - low address bits increment and wrap
// - latency 1.5 cycles strap high, else one
// - every transaction moves exactly four words
// - read/write select high means read
// - byte selects sampled with their data word
// - each byte select gates one nine-bit lane
// - outputs released when no read runs
// - echo clocks run continuously with input clock once link runs
// - collected write words committed internally
// - K rise starts every access
// - second read on consecutive K rise ignored
`timescale 1ns/100ps
module dbsp_sram_port #(
	parameter int DATA_W   = dbsp_pkg::DATA_W,
	parameter int ADDR_W   = dbsp_pkg::ADDR_W,
	parameter int ARRAY_AW = dbsp_pkg::ARRAY_AW
) (
	// core clock and reset
	input  wire logic                          core_clk,
	input  wire logic                          reset_n,
	// straps
	input  wire logic                          pll_off_n,
	input  wire logic                          c_clk_p,
	input  wire logic                          c_clk_n,
	// link clock and command
	input  wire logic                          link_clk,
	input  wire logic                          load_n,
	input  wire logic                          rw_sel,
	input  wire logic [ADDR_W-1:2]             addr,
	input  wire logic                          burst_addr_msb,
	input  wire logic                          burst_addr_lsb,
	// link data
	input  wire logic [DATA_W/dbsp_pkg::LANE_W-1:0] byte_lane_enable_n,
	input  wire logic [DATA_W-1:0]             dq_in,
	output logic      [DATA_W-1:0]             dq_out,
	output logic                               dq_oe,
	output logic                               return_strobe,
	output logic                               return_strobe_n,
	// status
	output logic                               ddr2_mode,
	output logic                               single_clk_mode,
	output logic                               link_ready
);
	localparam int LANES = DATA_W / dbsp_pkg::LANE_W;

	// **************************************************
	// helpers
	// **************************************************
	function automatic logic [ARRAY_AW-1:0] word_index(input logic [ADDR_W-1:0] base,
		input logic [1:0] beat);
		word_index = {base[ARRAY_AW-1:2], 2'(base[1:0] + beat)};
	endfunction

	function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
		input logic [DATA_W-1:0] new_w, input logic [LANES-1:0] lane_off);
		logic [DATA_W-1:0] merged;
		merged = old_w;
		for (int l = 0; l < LANES; l++)
			if (!lane_off[l])
				merged[l*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] =
					new_w[l*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W];
		lane_merge = merged;
	endfunction

	// **************************************************
	// core domain: strap capture
	// **************************************************
	logic [2:0]                 strap_sync;
	dbsp_pkg::dbsp_strap_st_t   st_reg;

	dbsp_sync #(.W(3)) u_strap_sync (
		.clk (core_clk),
		.d   ({c_clk_n, c_clk_p, pll_off_n}),
		.q   (strap_sync)
	);

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			st_reg <= dbsp_pkg::DBSP_ST_RESET;
		else
			unique case (st_reg)
				dbsp_pkg::DBSP_ST_RESET:  st_reg <= dbsp_pkg::DBSP_ST_SETTLE;
				dbsp_pkg::DBSP_ST_SETTLE: st_reg <= dbsp_pkg::DBSP_ST_RUN;
				dbsp_pkg::DBSP_ST_RUN:    st_reg <= dbsp_pkg::DBSP_ST_RUN;
				default:                  st_reg <= dbsp_pkg::DBSP_ST_RESET;
			endcase
	end

	// straps are caught once; later pin changes are ignored by design
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			ddr2_mode       <= 1'b0;
			single_clk_mode <= 1'b0;
		end
		else if (st_reg == dbsp_pkg::DBSP_ST_SETTLE)
		begin
			ddr2_mode       <= strap_sync[0];
			single_clk_mode <= strap_sync[1] && strap_sync[2];
		end
	end

	// run rises one cycle after the modes settle, so both cross stable
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			link_ready <= 1'b0;
		else
			link_ready <= (st_reg == dbsp_pkg::DBSP_ST_RUN);
	end

	// **************************************************
	// crossing into the link domain
	// **************************************************
	logic [1:0] link_sync;
	logic       lrun;
	logic       l_ddr2;

	dbsp_sync #(.W(2)) u_link_sync (
		.clk (link_clk),
		.d   ({ddr2_mode, link_ready}),
		.q   (link_sync)
	);

	assign lrun   = link_sync[0];
	assign l_ddr2 = link_sync[1];

	// **************************************************
	// link phase and echo clocks
	// **************************************************
	logic k_fall_reg;
	logic k_rise;

	assign k_rise = !k_fall_reg;

	always_ff @(posedge link_clk)
	begin
		if (!lrun)
			k_fall_reg <= 1'b0;
		else
			k_fall_reg <= !k_fall_reg;
	end

	always_ff @(posedge link_clk)
	begin
		if (!lrun)
		begin
			return_strobe   <= 1'b0;
			return_strobe_n <= 1'b1;
		end
		else
		begin
			return_strobe   <= k_rise;
			return_strobe_n <= !k_rise;
		end
	end

	// **************************************************
	// command decode
	// **************************************************
	logic              took_prev_reg;
	logic              load_take;
	logic              rd_start;
	logic              wr_start;
	logic [ADDR_W-1:0] cmd_addr;

	// load is honoured only on a K rise not directly after a taken one
	assign load_take = k_rise && !load_n && !took_prev_reg;
	assign rd_start  = load_take && rw_sel;
	assign wr_start  = load_take && !rw_sel;
	assign cmd_addr  = {addr, burst_addr_msb, burst_addr_lsb};

	always_ff @(posedge link_clk)
	begin
		if (!lrun)
			took_prev_reg <= 1'b0;
		else if (k_rise)
			took_prev_reg <= load_take;
	end

	// **************************************************
	// burst trackers
	// **************************************************
	logic              rd_beat_v;
	logic [1:0]        rd_beat_idx;
	logic [ADDR_W-1:0] rd_beat_addr;
	logic              rd_last;
	logic              wr_beat_v;
	logic [1:0]        wr_beat_idx;
	logic [ADDR_W-1:0] wr_base;
	logic              wr_last;

	dbsp_burst_slot #(.AW(ADDR_W)) u_rd_slot (
		.clk         (link_clk),
		.run         (lrun),
		.start       (rd_start),
		.start_addr  (cmd_addr),
		.start_delay (l_ddr2 ? dbsp_pkg::RD_DELAY_DDR2 : dbsp_pkg::RD_DELAY_DDR1),
		.beat_v      (rd_beat_v),
		.beat_idx    (rd_beat_idx),
		.beat_addr   (rd_beat_addr),
		.base_addr   (),
		.beat_last   (rd_last)
	);

	dbsp_burst_slot #(.AW(ADDR_W)) u_wr_slot (
		.clk         (link_clk),
		.run         (lrun),
		.start       (wr_start),
		.start_addr  (cmd_addr),
		.start_delay (dbsp_pkg::WR_DELAY),
		.beat_v      (wr_beat_v),
		.beat_idx    (wr_beat_idx),
		.beat_addr   (),
		.base_addr   (wr_base),
		.beat_last   (wr_last)
	);

	// **************************************************
	// storage and write collection
	// **************************************************
	logic [DATA_W-1:0] mem [0:2**ARRAY_AW-1];
	logic [DATA_W-1:0] wbuf_reg [0:dbsp_pkg::BURST_LEN-1];
	logic [LANES-1:0]  wben_reg [0:dbsp_pkg::BURST_LEN-1];

	// one word and its lane selects per link edge, K and K# alike
	always_ff @(posedge link_clk)
	begin
		if (wr_beat_v)
		begin
			wbuf_reg[wr_beat_idx] <= dq_in;
			wben_reg[wr_beat_idx] <= byte_lane_enable_n;
		end
	end

	// whole burst lands at once on the last beat; no external write pulse
	always_ff @(posedge link_clk)
	begin
		if (wr_beat_v && wr_last)
			for (int i = 0; i < dbsp_pkg::BURST_LEN; i++)
				mem[word_index(wr_base, 2'(i))] <= lane_merge(
					mem[word_index(wr_base, 2'(i))],
					(2'(i) == dbsp_pkg::BEAT_LAST) ? dq_in : wbuf_reg[i],
					(2'(i) == dbsp_pkg::BEAT_LAST) ? byte_lane_enable_n : wben_reg[i]);
	end

	// **************************************************
	// read launch
	// **************************************************
	always_ff @(posedge link_clk)
	begin
		if (!lrun)
		begin
			dq_oe  <= 1'b0;
			dq_out <= '0;
		end
		else
		begin
			dq_oe  <= rd_beat_v;
			dq_out <= rd_beat_v ? mem[rd_beat_addr[ARRAY_AW-1:0]] : '0;
		end
	end

	// **************************************************
	// checks
	// **************************************************
	logic [ARRAY_AW-1:0]        watch_idx;
	logic [ARRAY_AW-1:0]        watch_idx_reg;
	logic [dbsp_pkg::LANE_W-1:0] watch_lane0;
	logic [dbsp_pkg::LANE_W-1:0] kept_lane0;

	assign watch_idx   = word_index(wr_base, dbsp_pkg::BEAT_LAST);
	assign watch_lane0 = mem[watch_idx][dbsp_pkg::LANE_W-1:0];
	// base moves on once a following burst fires, so revisit the committed word
	assign kept_lane0  = mem[watch_idx_reg][dbsp_pkg::LANE_W-1:0];

	always_ff @(posedge link_clk)
	begin
		watch_idx_reg <= watch_idx;
	end

	rd_lat_two_a: assert property (@(posedge link_clk) disable iff (!lrun)
		(l_ddr2 && rd_start) |-> ##4 dq_oe[*4])
		else $error("read data late or short with strap high");
	rd_lat_one_a: assert property (@(posedge link_clk) disable iff (!lrun)
		(!l_ddr2 && rd_start) |-> ##3 dq_oe[*4])
		else $error("read data late or short with strap low");
	out_release_a: assert property (@(posedge link_clk) disable iff (!lrun)
		$fell(dq_oe) |-> $past(rd_last, 2))
		else $error("outputs released away from burst end");
	alt_edge_a: assert property (@(posedge link_clk) disable iff (!lrun)
		load_take |-> k_rise ##2 !load_take)
		else $error("transaction taken on consecutive input clock rises");
	beat_wrap_a: assert property (@(posedge link_clk) disable iff (!lrun)
		(rd_beat_v && !rd_last) |=>
			(rd_beat_v && rd_beat_addr[1:0] == 2'($past(rd_beat_addr[1:0]) + 2'h1)))
		else $error("burst address did not advance linearly");
	burst_load_a: assert property (@(posedge link_clk) disable iff (!lrun)
		(l_ddr2 && rd_start) |-> ##3
			(rd_beat_v && rd_beat_idx == dbsp_pkg::BEAT_FIRST &&
				rd_beat_addr[1:0] == $past(cmd_addr[1:0], 3)))
		else $error("burst counter not loaded from low address bits");
	wr_beats_a: assert property (@(posedge link_clk) disable iff (!lrun)
		wr_start |-> ##2 wr_beat_v[*4])
		else $error("write beats missing after write command");
	lane_keep_a: assert property (@(posedge link_clk) disable iff (!lrun)
		(wr_beat_v && wr_last && byte_lane_enable_n[0]) |=> kept_lane0 == $past(watch_lane0))
		else $error("deselected lane was altered");
	echo_run_a: assert property (@(posedge link_clk) disable iff (!lrun)
		1'b1 |=> (return_strobe != $past(return_strobe)) && (return_strobe_n != return_strobe))
		else $error("echo clocks stopped or not complementary");
endmodule // dbsp_sram_port

// >>> sim/dbsp_ctl_model.sv
// Purpose: far-side controller model driving commands and write beats
// Assumes: link running before issue(); one link edge per K or K# rise
// Notes:   write beats come from a slot table filled at command time
`timescale 1ns/100ps
module dbsp_ctl_model #(
	parameter int LN = dbsp_pkg::DATA_W / dbsp_pkg::LANE_W
) (
	// link side
	input  wire logic                        link_clk,
	input  wire logic                        return_strobe,
	// command
	output logic                             load_n,
	output logic                             rw_sel,
	output logic [dbsp_pkg::ADDR_W-1:2]      addr,
	output logic                             burst_addr_msb,
	output logic                             burst_addr_lsb,
	// data
	output logic [LN-1:0]                    byte_lane_enable_n,
	output logic [dbsp_pkg::DATA_W-1:0]      dq_in
);
	int unsigned                   edge_n;
	int unsigned                   nxt;
	event                          step;
	logic [dbsp_pkg::DATA_W-1:0]   slot_d [16];
	logic [LN-1:0]                 slot_l [16];
	bit                            slot_v [16];

	initial
	begin
		edge_n = 0;
		load_n = 1'b1;
		{rw_sel, addr, burst_addr_msb, burst_addr_lsb} = '0;
		byte_lane_enable_n = '1;
		dq_in = '0;
	end

	// ********************************
	// beat driver
	// ********************************
	// idle data lines toggle so a stale word never passes for a fresh one
	always @(posedge link_clk)
	begin
		#1;
		edge_n = edge_n + 1;
		nxt = (edge_n + 1) % 16;
		if (slot_v[nxt])
		begin
			dq_in = slot_d[nxt];
			byte_lane_enable_n = slot_l[nxt];
			slot_v[nxt] = 1'b0;
		end
		else
		begin
			dq_in = ~dq_in;
			byte_lane_enable_n = ~byte_lane_enable_n;
		end
		-> step;
	end

	// kind: 0 idle, 1 write, 2 read, 3 read placed on a K# edge
	task automatic issue(input int kind, input logic [dbsp_pkg::ADDR_W-1:0] a,
		input logic [dbsp_pkg::DATA_W-1:0] d [4], input logic [LN-1:0] l [4],
		output int e0);
		@(step);
		while (return_strobe !== 1'(kind == 3))
			@(step);
		e0 = int'(edge_n) + 1;
		load_n = (kind == 0);
		rw_sel = (kind != 1);
		addr = a[dbsp_pkg::ADDR_W-1:2];
		{burst_addr_msb, burst_addr_lsb} = a[1:0];
		for (int k = 0; k < 4 && kind == 1; k++)
		begin
			slot_d[(e0 + 2 + k) % 16] = d[k];
			slot_l[(e0 + 2 + k) % 16] = l[k];
			slot_v[(e0 + 2 + k) % 16] = 1'b1;
		end
		@(step);
		load_n = 1'b1;
		{rw_sel, addr, burst_addr_msb, burst_addr_lsb} = 21'($urandom);
	endtask
endmodule // dbsp_ctl_model

// >>> sim/ddr_burst4_sram_port_tb_top.sv
// Purpose: self-checking bench for the DDR burst-of-four port
// Assumes: array words 0..63 are filled before any random read
// Notes:   both strap settings are run, with a reset in between
`timescale 1ns/100ps
module ddr_burst4_sram_port_tb_top;
	localparam int LN = dbsp_pkg::DATA_W / dbsp_pkg::LANE_W;
	localparam int DW = dbsp_pkg::DATA_W;
	localparam int AW = dbsp_pkg::ADDR_W;
	logic                core_clk, reset_n, pll_off_n, c_clk_p, c_clk_n, link_clk;
	logic                load_n, rw_sel, a_msb, a_lsb, dq_oe, rs, rs_n;
	logic                ddr2_mode, single_clk_mode, link_ready;
	logic [AW-1:2]       addr;
	logic [LN-1:0]       lanes_n;
	logic [DW-1:0]       dq_in, dq_out;
	logic [DW-1:0]       mem [256];
	logic [DW-1:0]       exp_d [64];
	bit                  exp_v [64];
	bit                  run, prev_rs, prev_taken;
	int                  mismatches, n_tests, lat;

	dbsp_sram_port uut (
		.core_clk(core_clk), .reset_n(reset_n), .pll_off_n(pll_off_n),
		.c_clk_p(c_clk_p), .c_clk_n(c_clk_n), .link_clk(link_clk),
		.load_n(load_n), .rw_sel(rw_sel), .addr(addr),
		.burst_addr_msb(a_msb), .burst_addr_lsb(a_lsb),
		.byte_lane_enable_n(lanes_n), .dq_in(dq_in), .dq_out(dq_out),
		.dq_oe(dq_oe), .return_strobe(rs), .return_strobe_n(rs_n),
		.ddr2_mode(ddr2_mode), .single_clk_mode(single_clk_mode),
		.link_ready(link_ready)
	);

	dbsp_ctl_model ctl (
		.link_clk(link_clk), .return_strobe(rs), .load_n(load_n),
		.rw_sel(rw_sel), .addr(addr), .burst_addr_msb(a_msb),
		.burst_addr_lsb(a_lsb), .byte_lane_enable_n(lanes_n), .dq_in(dq_in)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	initial
	begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end

	// ********************************
	// checking
	// ********************************
	task automatic chk(input bit ok, input string msg);
		n_tests++;
		if (!ok)
		begin
			mismatches++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask

	task automatic end_sim();
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// every link edge: echo clocks, and either the expected word or released pins
	always @(ctl.step)
	begin
		if (!reset_n)
			run = 1'b0;
		else if (rs === 1'b1)
			run = 1'b1;
		if (run)
		begin
			chk(rs_n === ~rs && rs !== prev_rs, "echo clocks");
			if (exp_v[ctl.edge_n % 64])
				chk(dq_oe === 1'b1 && dq_out === exp_d[ctl.edge_n % 64], "read word");
			else
				chk(dq_oe === 1'b0, "pins driven outside a read");
			exp_v[ctl.edge_n % 64] = 1'b0;
		end
		prev_rs = rs;
	end

	// ********************************
	// stimulus
	// ********************************
	function automatic logic [AW-1:0] rnd_a();
		return {(AW-8)'($urandom), 2'h0, 6'($urandom)};
	endfunction

	// reference array updated at command time; commit lands before any later launch
	task automatic do_cmd(input int kind, input logic [AW-1:0] a, input bit full);
		logic [DW-1:0] d [4];
		logic [LN-1:0] l [4];
		int            e0;
		int            i;
		bit            taken;
		for (int k = 0; k < 4; k++)
		begin
			d[k] = DW'($urandom);
			l[k] = full ? '0 : LN'($urandom);
		end
		ctl.issue(kind, a, d, l, e0);
		taken = (kind == 1 || kind == 2) && !prev_taken;
		prev_taken = taken;
		for (int k = 0; k < 4 && taken; k++)
		begin
			i = int'({a[dbsp_pkg::ARRAY_AW-1:2], 2'(a[1:0] + k)});
			for (int j = 0; j < LN; j++)
				if (kind == 1 && !l[k][j])
					mem[i][j*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W] =
						d[k][j*dbsp_pkg::LANE_W +: dbsp_pkg::LANE_W];
			if (kind == 2)
			begin
				exp_v[(e0 + lat + k) % 64] = 1'b1;
				exp_d[(e0 + lat + k) % 64] = mem[i];
			end
		end
	endtask

	task automatic phase(input bit strap, input bit single);
		int n;
		int kind;
		@(posedge core_clk);
		#1;
		reset_n = 1'b0;
		pll_off_n = strap;
		c_clk_p = single;
		c_clk_n = single;
		prev_taken = 1'b0;
		lat = strap ? dbsp_pkg::RD_LAT_DDR2_HALF : dbsp_pkg::RD_LAT_DDR1_HALF;
		repeat (12) @(posedge core_clk);
		#1;
		reset_n = 1'b1;
		n = 0;
		while (!run && n < 300)
		begin
			@(ctl.step);
			n++;
		end
		chk(run && ddr2_mode === strap && single_clk_mode === single && link_ready === 1'b1,
			"start-up state");
		for (int g = 0; g < 16; g++)
		begin
			do_cmd(1, {(AW-8)'($urandom), 2'h0, 4'(g), 2'h0}, 1'b1);
			do_cmd(0, rnd_a(), 1'b0);
		end
		for (int it = 0; it < 80; it++)
		begin
			kind = $urandom_range(1, 2);
			do_cmd(kind, rnd_a(), 1'b0);
			case ($urandom_range(0, 3))
				0: do_cmd(2, rnd_a(), 1'b0);
				1: do_cmd(3, rnd_a(), 1'b0);
				default: ;
			endcase
			do_cmd(0, rnd_a(), 1'b0);
		end
		repeat (4) do_cmd(0, rnd_a(), 1'b0);
	endtask

	initial
	begin
		void'($urandom(32'hD52D0A84));
		mismatches = 0;
		n_tests = 0;
		lat = dbsp_pkg::RD_LAT_DDR2_HALF;
		reset_n = 1'b0;
		pll_off_n = 1'b1;
		c_clk_p = 1'b0;
		c_clk_n = 1'b0;
		phase(1'b1, 1'b0);
		phase(1'b0, 1'b1);
		end_sim();
	end

	// about four times the expected length of both phases
	initial
	begin
		#30000;
		mismatches++;
		end_sim();
	end
endmodule // ddr_burst4_sram_port_tb_top
